// ==== wd_supply_cfg.svh ====
// Purpose: Named constants for the host watchdog and supply control block.
// Assumes: Register indexes count 32-bit words on the AXI4-Lite bus.
// Notes: Byte address is four times the index.
`ifndef WD_SUPPLY_CFG_SVH
`define WD_SUPPLY_CFG_SVH

`define IDX_WD 8'h00
`define IDX_SC 8'h01
`define IDX_AC1 8'h02
`define IDX_AST 8'h03
`define IDX_REV 8'h05
`define IDX_IRQ_STAT 8'h08
`define IDX_IRQ_MASK 8'h09
`define IDX_LSB 2

`define WD_RST 8'h0f
`define WD_WMASK 8'h8f
`define WD_EN_BIT 7
`define WD_SEL_HI 3

`define SC_RST 8'h74
`define SC_WMASK 8'h7f
`define SC_HV_BIT 6
`define SC_DC2_BIT 5
`define SC_CLK_BIT 4
`define SC_TX_BIT 3
`define SC_TRIM_HI 2
`define SC_TRIM_RST 3'h4

`define AC1_RST 8'h60
`define AC1_WMASK 8'h7e

`define IRQ_WD_BIT 0
`define IRQ_RST 8'h00
`define IRQ_WMASK 8'h01

`define CLK_MHZ 100
`define WD_STEP_US 32768

`endif

// ==== wd_supply_pkg.sv ====
// Purpose: Shared types for the host watchdog and supply control block.
// Assumes: Standard AXI4-Lite response codes.
// Notes: Constants live in wd_supply_cfg.svh.
package wd_supply_pkg;

  typedef enum logic [1:0] {
    resp_okay = 2'b00,
    resp_slverr = 2'b10
  } resp_e;

  typedef logic [7:0] byte_t;

endpackage : wd_supply_pkg

// ==== host_watchdog_and_supply_ctrl.sv ====
// Purpose: Watchdog and supply control registers behind an AXI4-Lite slave.
// Assumes: One clock, synchronous active-low reset, tx_activity synchronous.
// Notes: Registers are 8 bits in the low byte of each word.
// Operation
// - Word indexes 0, 1, 2, 3, 5, 8 and 9 decode the watchdog, two control, status, revision, interrupt status and interrupt mask registers.
// - The watchdog register has enable at bit 7, period select at bits 3 to 0, and resets to 0x0f.
// - The period is code plus one times about 32.8 ms, from 33 ms up to 524 ms.
// - If the enable is not written again within the period, a watchdog event is raised.
// - Watchdog bits 6 to 4 are reserved and read zero.
// - Supply control resets to 0x74; bits 6, 5, 4 enable regulator, converter and clock out.
// - Supply control bit 3 enables the transmit monitor output and is clear after reset.
// - Supply control bits 2 to 0 hold the current-limit trim with reset value 100.
// - The monitor pin carries transmit activity while enabled and is undriven otherwise.
// - Supply control bit 7 is reserved and reads zero.
`timescale 1ns/10ps
`include "wd_supply_cfg.svh"

module host_watchdog_and_supply_ctrl #(
  parameter int AW = 8,
  parameter logic [31:0] STEP_CYCLES = `WD_STEP_US * `CLK_MHZ,
  parameter logic [7:0] REVISION = 8'h5a
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tx_activity,
  output logic hv_regulator_enable,
  output logic second_converter_enable,
  output logic clock_output_enable,
  output logic [2:0] hv_regulator_current_trim,
  output logic tx_monitor_pin_out,
  output logic tx_monitor_pin_oe,
  output logic watchdog_event,
  output logic irq
);

  // The revision value above is arbitrary.

  function automatic logic [7:0] reg_index(input logic [AW-1:0] a);
    reg_index = 8'(a >> `IDX_LSB);
  endfunction : reg_index

  function automatic logic is_mapped(input logic [AW-1:0] a);
    logic [7:0] i;
    i = reg_index(a);
    is_mapped = (i == `IDX_WD) || (i == `IDX_SC) || (i == `IDX_AC1) ||
      (i == `IDX_AST) || (i == `IDX_REV) || (i == `IDX_IRQ_STAT) ||
      (i == `IDX_IRQ_MASK);
  endfunction : is_mapped

  wd_supply_pkg::byte_t wd_q;
  wd_supply_pkg::byte_t sc_q;
  wd_supply_pkg::byte_t ac1_q;
  wd_supply_pkg::byte_t stat_q;
  wd_supply_pkg::byte_t stat_d;
  wd_supply_pkg::byte_t mask_q;
  logic [31:0] div_cnt_q;
  logic [3:0] step_cnt_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_full_q;
  logic w_full_q;
  logic tx_out_q;
  logic event_q;
  logic irq_q;

  // Bus handshakes and decode.
  wire aw_hs = awvalid && awready_q;
  wire w_hs = wvalid && wready_q;
  wire b_hs = bvalid_q && bready;
  wire ar_hs = arvalid && arready_q;
  wire r_hs = rvalid_q && rready;
  wire wr_do = aw_full_q && w_full_q && !bvalid_q;
  wire wr_ok = wr_do && is_mapped(aw_addr_q) && w_strb_q[0];
  wire [7:0] wr_idx = reg_index(aw_addr_q);
  wire [7:0] wr_byte = w_data_q[7:0];
  wire wr_wd = wr_ok && (wr_idx == `IDX_WD);
  wire wr_sc = wr_ok && (wr_idx == `IDX_SC);
  wire wr_ac1 = wr_ok && (wr_idx == `IDX_AC1);
  wire wr_stat = wr_ok && (wr_idx == `IDX_IRQ_STAT);
  wire wr_mask = wr_ok && (wr_idx == `IDX_IRQ_MASK);
  wire [7:0] rd_idx = reg_index(araddr);
  wire rd_ok = is_mapped(araddr);

  // Read selection; the analog status word reads zero here because the
  // monitors themselves sit outside this block.
  wire [7:0] rd_byte =
    (rd_idx == `IDX_WD) ? wd_q :
    (rd_idx == `IDX_SC) ? sc_q :
    (rd_idx == `IDX_AC1) ? ac1_q :
    (rd_idx == `IDX_REV) ? REVISION :
    (rd_idx == `IDX_IRQ_STAT) ? stat_q :
    (rd_idx == `IDX_IRQ_MASK) ? mask_q : 8'h00;

  // Watchdog timing.
  wire wd_run = wd_q[`WD_EN_BIT];
  wire [3:0] wd_sel = wd_q[`WD_SEL_HI:0];
  wire wd_kick = wr_wd && wr_byte[`WD_EN_BIT];
  wire step_hit = (div_cnt_q == STEP_CYCLES - 32'h1);
  wire wd_fire = wd_run && !wd_kick && step_hit &&
    (step_cnt_q == wd_sel);

  // A new timeout wins over a write-one-to-clear in the same cycle.
  wire [7:0] stat_set = {7'h00, wd_fire};
  wire [7:0] stat_clr = wr_stat ? (wr_byte & `IRQ_WMASK) : 8'h00;
  assign stat_d = (stat_q & ~stat_clr) | stat_set;
  wire [7:0] mask_d = wr_mask ? (wr_byte & `IRQ_WMASK) : mask_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_addr_q <= awaddr;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end else if (b_hs) begin
        aw_full_q <= 1'b0;
        awready_q <= 1'b1;
      end
      if (w_hs) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end else if (b_hs) begin
        w_full_q <= 1'b0;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= wd_supply_pkg::resp_okay;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_mapped(aw_addr_q) ? wd_supply_pkg::resp_okay :
        wd_supply_pkg::resp_slverr;
    end else if (b_hs) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= wd_supply_pkg::resp_okay;
      rdata_q <= 32'h0;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? wd_supply_pkg::resp_okay :
        wd_supply_pkg::resp_slverr;
      rdata_q <= {24'h000000, rd_byte};
    end else if (r_hs) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Reserved bits are masked on write so they always read zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_q <= `WD_RST;
      sc_q <= `SC_RST;
      ac1_q <= `AC1_RST;
    end else begin
      if (wr_wd) begin
        wd_q <= wr_byte & `WD_WMASK;
      end
      if (wr_sc) begin
        sc_q <= wr_byte & `SC_WMASK;
      end
      if (wr_ac1) begin
        ac1_q <= wr_byte & `AC1_WMASK;
      end
    end
  end

  // After a timeout the count starts over, so an ignored watchdog keeps
  // raising events once per period until software disables or kicks it.
  always_ff @(posedge aclk) begin
    if (!aresetn || wd_kick || !wd_run) begin
      div_cnt_q <= 32'h0;
      step_cnt_q <= 4'h0;
    end else if (step_hit) begin
      div_cnt_q <= 32'h0;
      step_cnt_q <= (step_cnt_q == wd_sel) ? 4'h0 : step_cnt_q + 4'h1;
    end else begin
      div_cnt_q <= div_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= `IRQ_RST;
      mask_q <= `IRQ_RST;
      irq_q <= 1'b0;
      event_q <= 1'b0;
      tx_out_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= |(stat_d & mask_d);
      event_q <= wd_fire;
      tx_out_q <= sc_q[`SC_TX_BIT] && tx_activity;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign hv_regulator_enable = sc_q[`SC_HV_BIT];
  assign second_converter_enable = sc_q[`SC_DC2_BIT];
  assign clock_output_enable = sc_q[`SC_CLK_BIT];
  assign hv_regulator_current_trim = sc_q[`SC_TRIM_HI:0];
  assign tx_monitor_pin_out = tx_out_q;
  assign tx_monitor_pin_oe = sc_q[`SC_TX_BIT];
  assign watchdog_event = event_q;
  assign irq = irq_q;

  // Helper for the period checks: it counts enabled, unkicked cycles on its
  // own, so a slip in the divider chain shows against the selected period.
  logic [35:0] run_len_q;
  wire [35:0] period_len = 36'(wd_sel + 5'h1) * 36'(STEP_CYCLES);

  always_ff @(posedge aclk) begin
    if (!aresetn || wd_kick || !wd_run || wd_fire) begin
      run_len_q <= 36'h0;
    end else begin
      run_len_q <= run_len_q + 36'h1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  rev_read_a: assert property (
    ar_hs && (rd_idx == `IDX_REV) |=> rdata == {24'h000000, REVISION} &&
      rresp == wd_supply_pkg::resp_okay)
    else $error("revision word read wrong");

  wd_reset_a: assert property (
    $past(!aresetn) |-> wd_q == `WD_RST && !watchdog_event)
    else $error("watchdog register reset value wrong");

  period_end_a: assert property (
    wd_fire |-> run_len_q == period_len - 36'h1)
    else $error("watchdog fired before its period");

  period_due_a: assert property (
    wd_run && !wd_kick && run_len_q == period_len - 36'h1 |-> wd_fire)
    else $error("watchdog period ran out without an event");

  wd_event_a: assert property (
    wd_fire |=> watchdog_event && stat_q[`IRQ_WD_BIT] ##1 !watchdog_event)
    else $error("watchdog timeout not flagged");

  wd_rsv_a: assert property (
    (wd_q & ~`WD_WMASK) == 8'h00 && (sc_q & ~`SC_WMASK) == 8'h00)
    else $error("watchdog reserved bits not zero");

  sc_reset_a: assert property (
    $past(!aresetn) |-> hv_regulator_enable && second_converter_enable &&
      clock_output_enable && sc_q == `SC_RST)
    else $error("supply control reset value wrong");

  tx_off_a: assert property (
    $past(!aresetn) |-> !tx_monitor_pin_oe && !tx_monitor_pin_out)
    else $error("transmit monitor enabled after reset");

  trim_reset_a: assert property (
    $past(!aresetn) |-> hv_regulator_current_trim == `SC_TRIM_RST)
    else $error("current trim reset value wrong");

  tx_follow_a: assert property (
    tx_monitor_pin_oe && $past(tx_monitor_pin_oe) |->
      tx_monitor_pin_out == $past(tx_activity))
    else $error("monitor pin does not follow activity");

  sc_rsv_a: assert property (
    wr_sc |=> sc_q == ($past(wr_byte) & `SC_WMASK))
    else $error("supply control write stored wrong");

  kick_a: assert property (
    wd_kick |=> div_cnt_q == 32'h0 && step_cnt_q == 4'h0 && !watchdog_event)
    else $error("watchdog kick did not restart count");

  irq_level_a: assert property (
    irq == (stat_q[`IRQ_WD_BIT] && mask_q[`IRQ_WD_BIT]))
    else $error("interrupt without unmasked status");

  rd_unmapped_a: assert property (
    ar_hs && !rd_ok |=> rdata == 32'h0 &&
      rresp == wd_supply_pkg::resp_slverr)
    else $error("unmapped read not refused");

  bvalid_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

endmodule : host_watchdog_and_supply_ctrl

// ==== tx_line_model.sv ====
// Purpose: Far-side model of the transmit monitor line.
// Assumes: Transmit activity toggles every clock.
// Notes: The pin has a pull-up, so a released pin reads high.
`timescale 1ns/10ps
module tx_line_model (
  input wire logic aclk,
  input wire logic out,
  input wire logic oe,
  output logic tx_activity,
  output wire pin
);
  // A toggling level makes a stuck or late monitor copy show at once.
  initial tx_activity = 1'b0;
  always @(posedge aclk) tx_activity <= ~tx_activity;
  assign pin = oe ? out : 1'b1;
endmodule : tx_line_model

// ==== host_watchdog_and_supply_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the watchdog and supply control block.
// Assumes: Short watchdog step of 8 clocks.
// Notes: Byte address is four times the register index.
`timescale 1ns/10ps
module host_watchdog_and_supply_ctrl_tb_top;
  localparam logic [7:0] REV = 8'h3c;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_activity;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic hv, dc2, ck, oe, pout, ev, irq, pin;
  logic [2:0] trim;
  int fails = 0;
  int n_checks = 0;
  int n;

  always #5 aclk = ~aclk;

  host_watchdog_and_supply_ctrl #(.STEP_CYCLES(32'h8), .REVISION(REV)) i_dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .tx_activity, .hv_regulator_enable(hv), .second_converter_enable(dc2),
    .clock_output_enable(ck), .hv_regulator_current_trim(trim),
    .tx_monitor_pin_out(pout), .tx_monitor_pin_oe(oe),
    .watchdog_event(ev), .irq(irq)
  );

  tx_line_model i_line (.aclk(aclk), .out(pout), .oe(oe),
    .tx_activity(tx_activity), .pin(pin));

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    chk(bvalid === 1'b1 && bresp === wd_supply_pkg::resp_okay,
      "write response");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] v, input bit e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    chk(rvalid === 1'b1 && rdata === {24'h0, v} &&
      rresp === (e ? wd_supply_pkg::resp_slverr :
      wd_supply_pkg::resp_okay), "read data");
  endtask : rd

  // Counts clocks from the task call to the event pulse.
  task automatic wd_wait(input int lo, input int hi);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (ev !== 1'b1 && n < hi + 5);
    chk(n >= lo && n <= hi, "watchdog period");
  endtask : wd_wait

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial begin
    #100us;
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 8'h0f, 1'b0);
    rd(8'h04, 8'h74, 1'b0);
    chk({hv, dc2, ck, oe, trim} === 7'h74, "reset outputs");
    rd(8'h14, REV, 1'b0);
    rd(8'h0c, 8'h00, 1'b0);
    rd(8'h3c, 8'h00, 1'b1);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h7f, 1'b0);
    @(posedge aclk);
    chk({oe, pout} === {1'b1, ~tx_activity}, "monitor on");
    wr(8'h04, 8'h02);
    @(posedge aclk);
    chk({hv, dc2, ck, oe, pout, trim} === 8'h02, "controls off");
    chk(pin === 1'b1, "pin released");
    wr(8'h24, 8'h01);
    wr(8'h00, 8'hf0);
    rd(8'h00, 8'h80, 1'b0);
    wd_wait(4, 9);
    @(posedge aclk);
    chk(irq === 1'b1, "irq raised");
    rd(8'h20, 8'h01, 1'b0);
    wr(8'h00, 8'h03);
    wr(8'h20, 8'h01);
    @(posedge aclk);
    chk(irq === 1'b0, "irq cleared");
    // A kick late in the period must push the event a full period out.
    wr(8'h00, 8'h83);
    repeat (20) @(posedge aclk);
    wr(8'h00, 8'h83);
    wd_wait(28, 33);
    wr(8'h00, 8'h0f);
    wr(8'h20, 8'h01);
    wr(8'h24, 8'h00);
    wr(8'h00, 8'h81);
    wd_wait(12, 17);
    @(posedge aclk);
    chk(irq === 1'b0, "irq masked");
    wr(8'h00, 8'h0f);
    n = 0;
    repeat (300) begin
      @(posedge aclk);
      if (ev !== 1'b0) n++;
    end
    chk(n == 0, "disabled watchdog fired");
    // A reset in mid-run must bring back the supply defaults and drop status.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04, 8'h74, 1'b0);
    rd(8'h20, 8'h00, 1'b0);
    tally_and_finish();
  end
endmodule : host_watchdog_and_supply_ctrl_tb_top
